// ===== hdl/light_sync_defs.vh
/*
  Constants for the external-timing sequencer of the light sensor: register
  offsets, command register fields, I2C address and timing counts.
  Assumes a 25 MHz core clock; included by bare name.
*/
`ifndef LIGHT_SYNC_DEFS_VH
`define LIGHT_SYNC_DEFS_VH

`define I2C_ADDR 7'h44
`define REG_CMD 8'h00
`define REG_DATA_LSB 8'h04
`define REG_DATA_MSB 8'h05
`define REG_TIMER_LSB 8'h06
`define REG_TIMER_MSB 8'h07
`define CMD_RESET 8'h00
`define CMD_EXT_BIT 5
`define CMD_RANGE_HI 3
`define CMD_RANGE_LO 2
`define CMD_WIDTH_HI 1
`define CMD_WIDTH_LO 0
// Command byte that acts as an integration sync instead of a register pointer
`define SYNC_CMD 8'h80
`define CORE_HZ 25000000
`define OSC_SLOW_HZ 327000
`define OSC_FAST_HZ 655000
// Core clocks per full oscillator cycle, one tick each
`define OSC_SLOW_DIV (`CORE_HZ / `OSC_SLOW_HZ)
`define OSC_FAST_DIV (`CORE_HZ / `OSC_FAST_HZ)

`endif

// ===== hdl/light_sync_seq.v
/*
  I2C target with command/data/timer registers and the three-sync external
  timing sequencer of an integrating light sensor.
  Assumes SCL/SDA arrive from pins (synchronised here), open-drain wiring
  resolved outside, and a light count supplied by the analog front end.
*/
`default_nettype none
`include "light_sync_defs.vh"

module light_sync_seq (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_oe_o,
  output reg sda_o,
  input wire [15:0] light_count_i,
  output reg array1_conv_o,
  output reg array2_conv_o,
  output reg ext_mode_o,
  output reg [1:0] width_sel_o,
  output reg osc_tick_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_READ = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [1:0] SEQ_WAIT = 2'h0;
  localparam [1:0] SEQ_ARR1 = 2'h1;
  localparam [1:0] SEQ_ARR2 = 2'h2;
  localparam integer SLOW_DIV_N = `OSC_SLOW_DIV;
  localparam integer FAST_DIV_N = `OSC_FAST_DIV;
  localparam [7:0] SLOW_DIV = SLOW_DIV_N[7:0];
  localparam [7:0] FAST_DIV = FAST_DIV_N[7:0];

  reg [1:0] scl_s_r;
  reg [1:0] sda_s_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [2:0] state_r;
  reg [2:0] bit_r;
  reg [7:0] shift_r;
  reg rw_r;
  reg first_r;
  reg [7:0] ptr_r;
  reg [7:0] cmd_r;
  reg [15:0] data_r;
  reg [15:0] timer_r;
  reg [15:0] cyc_r;
  reg [1:0] seq_r;
  reg [7:0] div_r;
  reg sync_r;
  reg full_r;

  wire scl_rise = scl_s_r[1] & ~scl_d_r;
  wire scl_fall = ~scl_s_r[1] & scl_d_r;
  wire start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  wire stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
  wire [7:0] shift_nxt = {shift_r[6:0], sda_s_r[1]};
  // A tick in the closing cycle still belongs to the window being closed
  wire [15:0] cyc_inc = (osc_tick_o && cyc_r != 16'hffff) ? cyc_r + 16'h0001 : cyc_r;

  function [7:0] reg_read;
    input [7:0] addr;
    begin
      case (addr)
        `REG_CMD: reg_read = cmd_r;
        `REG_DATA_LSB: reg_read = data_r[7:0];
        `REG_DATA_MSB: reg_read = data_r[15:8];
        `REG_TIMER_LSB: reg_read = timer_r[7:0];
        `REG_TIMER_MSB: reg_read = timer_r[15:8];
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // Pins pass two flops before anything looks at them
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // I2C target; pointer write of the sync byte raises a sync event
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      bit_r <= 3'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ptr_r <= 8'h00;
      cmd_r <= `CMD_RESET;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      sync_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      sync_r <= 1'b0;
      if (start_c) begin
        state_r <= ST_ADDR;
        bit_r <= 3'h0;
        full_r <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: sda_oe_o <= 1'b0;
          ST_ADDR: begin
            if (scl_rise) begin
              shift_r <= shift_nxt;
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7)
                full_r <= 1'b1;
            end
            // The fall closing the start condition carries no address, and stale bytes must not match
            if (scl_fall && full_r) begin
              full_r <= 1'b0;
              if (shift_r[7:1] == `I2C_ADDR) begin
                rw_r <= shift_r[0];
                first_r <= 1'b1;
                sda_oe_o <= 1'b1;
                state_r <= ST_ACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ACK: if (scl_fall) begin
            bit_r <= 3'h0;
            if (rw_r) begin
              shift_r <= reg_read(ptr_r);
              sda_oe_o <= ~|(reg_read(ptr_r) & 8'h80);
              state_r <= ST_READ;
            end else begin
              sda_oe_o <= 1'b0;
              state_r <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= shift_nxt;
              bit_r <= bit_r + 3'h1;
            end
            if (scl_fall && bit_r == 3'h0) begin
              sda_oe_o <= 1'b1;
              state_r <= ST_ACK;
              if (first_r && shift_r == `SYNC_CMD) begin
                sync_r <= 1'b1;
              end else if (first_r) begin
                ptr_r <= shift_r;
              end else begin
                if (ptr_r == `REG_CMD)
                  cmd_r <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
              first_r <= 1'b0;
            end
          end
          ST_READ: if (scl_fall) begin
            bit_r <= bit_r + 3'h1;
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_o <= (bit_r == 3'h7) ? 1'b0 : ~shift_r[6];
            if (bit_r == 3'h7) begin
              state_r <= ST_RACK;
              ptr_r <= ptr_r + 8'h01;
            end
          end
          ST_RACK: if (scl_rise) begin
            state_r <= sda_s_r[1] ? ST_IDLE : ST_ACK;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Oscillator rate set by range only, same in both timing modes
  wire fast_c = cmd_r[`CMD_RANGE_HI];
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= 8'h00;
      osc_tick_o <= 1'b0;
    end else if (div_r >= (fast_c ? FAST_DIV : SLOW_DIV) - 8'h01) begin
      div_r <= 8'h00;
      osc_tick_o <= 1'b1;
    end else begin
      div_r <= div_r + 8'h01;
      osc_tick_o <= 1'b0;
    end
  end

  // Sequencer: three syncs per measurement
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_r <= SEQ_WAIT;
      cyc_r <= 16'h0000;
      data_r <= 16'h0000;
      timer_r <= 16'h0000;
      array1_conv_o <= 1'b0;
      array2_conv_o <= 1'b0;
      ext_mode_o <= 1'b0;
      width_sel_o <= 2'h0;
    end else begin
      ext_mode_o <= cmd_r[`CMD_EXT_BIT];
      width_sel_o <= cmd_r[`CMD_WIDTH_HI:`CMD_WIDTH_LO];
      if (!cmd_r[`CMD_EXT_BIT]) begin
        seq_r <= SEQ_WAIT;
        array1_conv_o <= 1'b0;
        array2_conv_o <= 1'b0;
      end else begin
        // Saturate instead of wrapping so an overlong period stays visible
        if (seq_r != SEQ_WAIT)
          cyc_r <= cyc_inc;
        if (sync_r) begin
          case (seq_r)
            SEQ_WAIT: begin
              seq_r <= SEQ_ARR1;
              cyc_r <= 16'h0000;
              array1_conv_o <= 1'b1;
            end
            SEQ_ARR1: begin
              seq_r <= SEQ_ARR2;
              array1_conv_o <= 1'b0;
              array2_conv_o <= 1'b1;
            end
            SEQ_ARR2: begin
              seq_r <= SEQ_ARR1;
              data_r <= light_count_i;
              timer_r <= cyc_inc;
              cyc_r <= 16'h0000;
              array1_conv_o <= 1'b1;
              array2_conv_o <= 1'b0;
            end
            default: seq_r <= SEQ_WAIT;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verif/light_sync_monitor.sv
/* Port checker for the sync sequencer.
   Assumes binding onto light_sync_seq. */
`default_nettype none
module light_sync_monitor (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic sda_o,
  input wire logic array1_conv_o,
  input wire logic array2_conv_o,
  input wire logic ext_mode_o,
  input wire logic osc_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] gap_r;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) gap_r <= 8'h00;
    else gap_r <= osc_tick_o ? 8'h00 : gap_r + 8'h01;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence quiet_s;
    !osc_tick_o [*8];
  endsequence
  AST_EXCL: assert property (!(array1_conv_o && array2_conv_o))
    else $error("both arrays converting");
  AST_IDLE: assert property (!ext_mode_o && !$past(ext_mode_o) |-> !array1_conv_o && !array2_conv_o)
    else $error("array active in internal mode");
  AST_HAND: assert property ($fell(array1_conv_o) && ext_mode_o |-> $rose(array2_conv_o))
    else $error("no handover to array two");
  AST_LOOP: assert property ($fell(array2_conv_o) && ext_mode_o |-> $rose(array1_conv_o))
    else $error("no restart of array one");
  AST_ACK_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data pulled while clock high");
  AST_SDA_ZERO: assert property (!sda_o)
    else $error("data line driven high");
  AST_TICK_GAP: assert property (osc_tick_o |=> quiet_s)
    else $error("oscillator ticks too close");
  // Slow period is 76 clocks; the first period after reset shows one count more
  AST_TICK_MAX: assert property (gap_r <= 8'h4c)
    else $error("oscillator tick late");
endmodule
bind light_sync_seq light_sync_monitor light_sync_monitor_inst (.core_clk_i, .sys_rst_i, .scl_i, .sda_oe_o,
  .sda_o, .array1_conv_o, .array2_conv_o, .ext_mode_o, .osc_tick_o);
`default_nettype wire

// ===== verif/i2c_host_model.sv
/* Behavioural I2C host.
   Assumes 320 ns bit time and a pulled-up data wire resolved outside. */
`default_nettype none
module i2c_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task q;
    repeat (2) @(negedge clk_i);
  endtask
  task start;
    sda_o = 1'b0;
    q;
    scl_o = 1'b0;
    q;
  endtask
  task stop;
    sda_o = 1'b0;
    q;
    scl_o = 1'b1;
    q;
    sda_o = 1'b1;
    q;
  endtask
  // Data only moves while the clock is low
  task xb(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_o = d[i];
      q;
      scl_o = 1'b1;
      q;
      r[i] = sda_i;
      q;
      scl_o = 1'b0;
      q;
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/light_sensor_external_sync_timing_test.sv
/* Bench for the sync sequencer.
   Assumes the design's constants header. */
`default_nettype none
`include "light_sync_defs.vh"
module light_sensor_external_sync_timing_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] light = 16'h0000;
  logic scl, sdah, oe, a1, a2, ext, tick;
  logic [1:0] wsel;
  logic [8:0] q;
  logic [7:0] r;
  int miscompares = 0, checked = 0, ticks = 0, t1 = 0;
  logic a2_q = 1'b0;
  wire sda = sdah & ~oe;
  always #20 clk = ~clk;
  // Oscillator cycles inside an open window, looked at mid-cycle
  always @(negedge clk) begin
    if (a2_q && !a2) t1 = ticks;
    if (tick && (a1 || a2)) ticks = ticks + 1;
    a2_q = a2;
  end
  light_sync_seq light_sync_seq_inst (.core_clk_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda),
    .sda_oe_o(oe), .sda_o(), .light_count_i(light), .array1_conv_o(a1), .array2_conv_o(a2),
    .ext_mode_o(ext), .width_sel_o(wsel), .osc_tick_o(tick));
  i2c_host_model i2c_host_model_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sdah));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task xw(input logic [7:0] d, input logic nak);
    i2c_host_model_inst.xb({d, 1'b1}, q);
    chk(16'(q[0]), 16'(nak));
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d);
    i2c_host_model_inst.start;
    xw(8'h88, 1'b0);
    xw(p, 1'b0);
    if (p != 8'h80) xw(d, 1'b0);
    i2c_host_model_inst.stop;
  endtask
  task rd(input logic [7:0] p, input logic [15:0] e);
    // Pointer only: a data byte here would move it on by one
    i2c_host_model_inst.start;
    xw(8'h88, 1'b0);
    xw(p, 1'b0);
    i2c_host_model_inst.stop;
    i2c_host_model_inst.start;
    xw(8'h89, 1'b0);
    i2c_host_model_inst.xb(9'h1fe, q);
    r = q[8:1];
    i2c_host_model_inst.xb(9'h1ff, q);
    i2c_host_model_inst.stop;
    chk({q[8:1], r}, e);
  endtask
  task per(input int e);
    int n;
    n = 0;
    @(negedge clk iff tick);
    do begin
      @(negedge clk);
      n++;
    end while (!tick);
    chk(16'(n), 16'(e));
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk({ext, wsel}, 16'h0);
    i2c_host_model_inst.start;
    xw(8'h8a, 1'b1);
    i2c_host_model_inst.stop;
    wr(8'h80, 8'h00);
    chk({a1, a2}, 16'h0);
    wr(8'h00, 8'h23);
    chk({ext, wsel}, 16'h7);
    per(`OSC_SLOW_DIV);
    wr(8'h80, 8'h00);
    chk({a1, a2}, 16'h2);
    repeat (400) @(negedge clk);
    wr(8'h80, 8'h00);
    chk({a1, a2}, 16'h1);
    repeat (400) @(negedge clk);
    light = 16'h5a3c;
    wr(8'h80, 8'h00);
    chk({a1, a2}, 16'h2);
    rd(8'h04, 16'h5a3c);
    i2c_host_model_inst.xb(9'h1ff, q);
    chk(16'(q[0]), 16'h0001);
    i2c_host_model_inst.stop;
    // Two intervals of 154 + 400 core cycles each
    chk(16'((t1 == 1108 / `OSC_SLOW_DIV) || (t1 == 1108 / `OSC_SLOW_DIV + 1)), 16'h0001);
    rd(8'h06, 16'(t1));
    rd(8'h10, 16'h0);
    wr(8'h00, 8'h08);
    chk({a1, a2, ext}, 16'h0);
    per(`OSC_FAST_DIV);
    wr(8'h00, 8'h20);
    wr(8'h80, 8'h00);
    chk({a1, a2}, 16'h2);
    complete_run;
  end
  initial begin
    #2ms;
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire
